// [rtl/msr_core.v]
// Master/slave reference sharing with droop, APB registers and link timing.
`timescale 1ns/1ps
`include "msr_defs.vh"
module msr_core #(
  parameter MS_CYCLES = `MSR_MS_NS / `MSR_CLK_NS
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg         pready,
  output reg  [31:0] prdata,
  output reg         pslverr,
  input  wire [15:0] freq_ref_in,
  input  wire [15:0] out_freq_in,
  input  wire [15:0] out_torque_in,
  input  wire        run_cmd_in,
  input  wire        fault_in,
  input  wire        rx_valid,
  input  wire [15:0] rx_data,
  input  wire        rx_run,
  input  wire        rx_fault,
  output reg         tx_valid,
  output reg  [15:0] tx_data,
  output reg         tx_run,
  output reg         tx_fault,
  output reg  [7:0]  node_addr,
  output reg  [15:0] freq_ref_out,
  output reg  [15:0] torque_ref_out,
  output reg         run_out,
  output reg         peer_fault,
  output reg         offline_alarm,
  output reg         sync_ok,
  output reg         irq
);
  ////////////////////////////////////////////////////////////////////////////
  reg [15:0] ctrl_q;
  reg [15:0] droop_q;
  reg [15:0] offset_q;
  reg [15:0] gain_q;
  reg [15:0] silence_q;
  reg [15:0] period_q;
  reg [15:0] window_q;
  reg [15:0] rated_q;
  reg [2:0]  status_q;
  reg [2:0]  mask_q;
  reg [15:0] actual_q;
  reg [15:0] rxref_q;
  reg [15:0] per_cnt_q;
  reg [31:0] sil_cnt_q;
  reg        offline_q;
  reg        unsync_q;
  reg        peer_run_q;

  wire       en      = ctrl_q[`MSR_CTRL_EN];
  wire       slave   = ctrl_q[`MSR_CTRL_ROLE];
  wire       torque  = ctrl_q[`MSR_CTRL_TORQUE];
  wire       dsrc    = ctrl_q[`MSR_CTRL_DSRC];
  wire [1:0] csrc    = ctrl_q[`MSR_CTRL_CSRC_HI:`MSR_CTRL_CSRC_LO];
  wire [2:0] action  = ctrl_q[`MSR_CTRL_ACT_HI:`MSR_CTRL_ACT_LO];
  wire       master  = en & ~slave;
  wire       slv_on  = en & slave;
  // Slave digits only have meaning while commands come over serial comms.
  wire       act_ok  = slv_on & (csrc == `MSR_CSRC_SERIAL); // R10
  wire       follow  = act_ok & action[0]; // R9
  wire       fwd     = act_ok & action[1]; // R9
  wire       alm_en  = act_ok & action[2]; // R9

  ////////////////////////////////////////////////////////////////////////////
  // Arithmetic: frequencies in 0.01 Hz, torque in 0.1 %, gain in 0.01.
  wire signed [15:0] ref_s   = freq_ref_in;
  wire signed [15:0] trq_s   = out_torque_in;
  wire signed [16:0] rated_s = {1'b0, rated_q};
  wire signed [16:0] rate_s  = {1'b0, droop_q};
  wire signed [49:0] droop_p = rated_s * trq_s * rate_s; // R1
  wire signed [49:0] droop_w = droop_p / `MSR_DROOP_DIV; // R1
  wire signed [16:0] act_w   = ref_s - droop_w[16:0]; // R2
  wire signed [15:0] rx_s    = rx_data;
  wire signed [15:0] gain_s  = gain_q;
  wire signed [15:0] ofs_s   = offset_q;
  wire signed [31:0] rx_p    = rx_s * gain_s; // R14
  wire signed [31:0] rx_g    = rx_p / `MSR_GAIN_DIV; // R14
  wire signed [31:0] rx_c    = rx_g + {{16{ofs_s[15]}}, ofs_s}; // R14
  // Signed operands, so a reference just below zero is still judged by its distance.
  wire signed [16:0] diff    = $signed(rxref_q) - $signed(out_freq_in);
  wire        [16:0] adiff   = diff[16] ? -diff : diff;
  wire        [15:0] tx_sel  = dsrc ? freq_ref_in : // R12
                               (droop_q != 16'h0) ? act_w[15:0] : out_freq_in; // R11

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, so pready and prdata both come from flops.
  wire acc    = psel & penable & pready;
  wire wr     = acc & pwrite;
  wire rd_st  = acc & ~pwrite & (paddr == `MSR_OFS_STATUS);
  reg  [31:0] rdata;
  reg         hit;

  function [15:0] lo16;
    input [31:0] d;
    begin
      lo16 = d[15:0];
    end
  endfunction

  always @* begin
    rdata = 32'h0;
    hit   = 1'b1;
    if (paddr == `MSR_OFS_CTRL) begin
      rdata = {16'h0, ctrl_q};
    end else if (paddr == `MSR_OFS_DROOP) begin
      rdata = {16'h0, droop_q};
    end else if (paddr == `MSR_OFS_OFFSET) begin
      rdata = {16'h0, offset_q};
    end else if (paddr == `MSR_OFS_GAIN) begin
      rdata = {16'h0, gain_q};
    end else if (paddr == `MSR_OFS_SILENCE) begin
      rdata = {16'h0, silence_q};
    end else if (paddr == `MSR_OFS_PERIOD) begin
      rdata = {16'h0, period_q};
    end else if (paddr == `MSR_OFS_WINDOW) begin
      rdata = {16'h0, window_q};
    end else if (paddr == `MSR_OFS_RATED) begin
      rdata = {16'h0, rated_q};
    end else if (paddr == `MSR_OFS_STATUS) begin
      rdata = {29'h0, status_q};
    end else if (paddr == `MSR_OFS_MASK) begin
      rdata = {29'h0, mask_q};
    end else if (paddr == `MSR_OFS_ACTUAL) begin
      rdata = {16'h0, actual_q};
    end else if (paddr == `MSR_OFS_RXREF) begin
      rdata = {16'h0, rxref_q};
    end else if (paddr == `MSR_OFS_NODE) begin
      rdata = {24'h0, node_addr};
    end else begin
      hit   = 1'b0;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready;
      prdata  <= (psel & penable & ~pready & ~pwrite) ? rdata : 32'h0;
      pslverr <= psel & penable & ~pready & ~hit;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q    <= {1'b0, `MSR_RST_ACTION, 12'h0}; // R5 R6 R9
      droop_q   <= `MSR_RST_DROOP;
      offset_q  <= `MSR_RST_OFFSET;
      gain_q    <= `MSR_RST_GAIN;
      silence_q <= `MSR_RST_SILENCE;
      period_q  <= `MSR_RST_PERIOD;
      window_q  <= `MSR_RST_WINDOW;
      rated_q   <= `MSR_RST_RATED;
      mask_q    <= 3'h0;
    end else if (wr) begin
      if (paddr == `MSR_OFS_CTRL) begin
        ctrl_q    <= lo16(pwdata) & 16'h731F; // R5 R6 R9
      end else if (paddr == `MSR_OFS_DROOP) begin
        droop_q   <= lo16(pwdata);
      end else if (paddr == `MSR_OFS_OFFSET) begin
        offset_q  <= lo16(pwdata);
      end else if (paddr == `MSR_OFS_GAIN) begin
        gain_q    <= lo16(pwdata);
      end else if (paddr == `MSR_OFS_SILENCE) begin
        silence_q <= lo16(pwdata);
      end else if (paddr == `MSR_OFS_PERIOD) begin
        period_q  <= lo16(pwdata);
      end else if (paddr == `MSR_OFS_WINDOW) begin
        window_q  <= lo16(pwdata);
      end else if (paddr == `MSR_OFS_RATED) begin
        rated_q   <= lo16(pwdata);
      end else if (paddr == `MSR_OFS_MASK) begin
        mask_q    <= pwdata[2:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  wire ms_tick;

  msr_tick #(
    .CYCLES (MS_CYCLES)
  ) u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (en),
    .tick    (ms_tick)
  );

  // A period of zero is treated as one millisecond rather than stopping.
  wire [15:0] per_lim = (period_q == 16'h0) ? 16'h1 : period_q;
  wire        send    = master & ms_tick & (per_cnt_q + 16'h1 >= per_lim); // R17

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_cnt_q <= 16'h0;
      tx_valid  <= 1'b0;
      tx_data   <= 16'h0;
      tx_run    <= 1'b0;
      tx_fault  <= 1'b0;
      node_addr <= 8'h0;
      actual_q  <= 16'h0;
    end else begin
      actual_q  <= act_w[15:0]; // R2
      node_addr <= !en ? 8'h0 : slave ? `MSR_NODE_SLAVE : `MSR_NODE_MASTER; // R7
      tx_valid  <= send; // R17
      if (!master) begin
        per_cnt_q <= 16'h0;
      end else if (send) begin
        per_cnt_q <= 16'h0;
      end else if (ms_tick) begin
        per_cnt_q <= per_cnt_q + 16'h1;
      end
      if (send) begin
        tx_data <= tx_sel; // R8 R11 R12
        tx_run  <= run_cmd_in; // R8
      end
      tx_fault  <= fwd & fault_in; // R9
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slave side: scale each frame and route it by control mode.
  wire frame  = en & rx_valid;
  wire in_win = {1'b0, window_q} >= adiff;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxref_q        <= 16'h0;
      freq_ref_out   <= 16'h0;
      torque_ref_out <= 16'h0;
      run_out        <= 1'b0;
      peer_fault     <= 1'b0;
      sync_ok        <= 1'b0;
      unsync_q       <= 1'b0;
      peer_run_q     <= 1'b0;
    end else begin
      if (slv_on & rx_valid) begin
        rxref_q <= rx_c[15:0]; // R14
        if (!torque) begin
          freq_ref_out   <= rx_c[15:0]; // R15
        end else begin
          torque_ref_out <= rx_c[15:0]; // R15
        end
      end
      if (!slv_on) begin
        freq_ref_out <= freq_ref_in;
      end
      if (slv_on & rx_valid) begin
        peer_run_q <= rx_run; // R9
      end
      // The peer's run line means nothing between frames, so the last frame's value is held.
      run_out    <= !follow ? run_cmd_in : rx_valid ? rx_run : peer_run_q; // R9
      peer_fault <= master & rx_valid & rx_fault;
      // Only a speed-controlled slave can be judged against the window.
      sync_ok    <= slv_on & ~torque & in_win; // R18
      unsync_q   <= slv_on & ~torque & ~in_win; // R18
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Silence timer in milliseconds; the 0.1 s setting is scaled up.
  wire [31:0] sil_lim = silence_q * `MSR_MS_PER_SILENT; // R16

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sil_cnt_q     <= 32'h0;
      offline_q     <= 1'b0;
      offline_alarm <= 1'b0;
    end else begin
      if (!en || silence_q == 16'h0) begin
        sil_cnt_q <= 32'h0; // R16
        offline_q <= 1'b0;
      end else if (frame) begin
        sil_cnt_q <= 32'h0; // R19
        offline_q <= 1'b0;
      end else if (ms_tick && !offline_q) begin
        if (sil_cnt_q + 32'h1 >= sil_lim) begin
          offline_q <= 1'b1; // R16
        end
        sil_cnt_q <= sil_cnt_q + 32'h1;
      end
      offline_alarm <= alm_en & offline_q; // R19
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky events; a set in the clearing read cycle survives.
  reg        offline_d1_q;
  reg        unsync_d1_q;
  wire [2:0] ev;

  assign ev[`MSR_ST_OFFLINE] = offline_q & ~offline_d1_q;
  assign ev[`MSR_ST_FRAME]   = frame;
  assign ev[`MSR_ST_UNSYNC]  = unsync_q & ~unsync_d1_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      offline_d1_q <= 1'b0;
      unsync_d1_q  <= 1'b0;
      status_q     <= 3'h0;
      irq          <= 1'b0;
    end else begin
      offline_d1_q <= offline_q;
      unsync_d1_q  <= unsync_q;
      status_q     <= (rd_st ? 3'h0 : status_q) | ev;
      irq          <= |(((rd_st ? 3'h0 : status_q) | ev) & mask_q);
    end
  end
endmodule // msr_core

// [rtl/msr_defs.vh]
// Offsets, field positions, reset values and timing constants of the reference sharing block.
// Summary of operation
// (R1) Droop speed is rated frequency times torque times rate.
// (R2) Actual frequency is reference minus droop speed.
// (R3) Use droop only with both drives speed-controlled.
// (R4) Program droop rate on both, 0 to 10 Hz.
// (R5) Link enable bit, 0 off, 1 on, resets 0.
// (R6) Role bit, 0 master, 1 slave, resets master.
// (R7) Node addresses assigned automatically when link enabled.
// (R8) Master sends a reference derived from its own.
// (R9) Slave digits: follow run, forward fault, offline alarm.
// (R10) Slave digits act only as slave with source 2.
// (R11) Source 0 sends droop frequency, else output frequency.
// (R12) Source 1 sends the frequency reference.
// (R13) Torque load sharing needs droop rate zero.
// (R14) Slave corrects received value with gain and offset.
// (R15) Corrected value feeds frequency or torque reference.
// (R16) Silence time 0 to 10 s detects interruption; 0 disables.
// (R17) Master sends every 1 ms to 10 s period.
// (R18) Keep slave speed within the sync window width.
// (R19) Valid frame restarts timer; expiry raises offline alarm.
`ifndef MSR_DEFS_VH
`define MSR_DEFS_VH

`define MSR_OFS_CTRL      8'h00
`define MSR_OFS_DROOP     8'h04
`define MSR_OFS_OFFSET    8'h08
`define MSR_OFS_GAIN      8'h0C
`define MSR_OFS_SILENCE   8'h10
`define MSR_OFS_PERIOD    8'h14
`define MSR_OFS_WINDOW    8'h18
`define MSR_OFS_RATED     8'h1C
`define MSR_OFS_STATUS    8'h20
`define MSR_OFS_MASK      8'h24
`define MSR_OFS_ACTUAL    8'h28
`define MSR_OFS_RXREF     8'h2C
`define MSR_OFS_NODE      8'h30

`define MSR_CTRL_EN       0
`define MSR_CTRL_ROLE     1
`define MSR_CTRL_TORQUE   2
`define MSR_CTRL_DSRC     3
`define MSR_CTRL_CSRC_LO  8
`define MSR_CTRL_CSRC_HI  9
`define MSR_CTRL_ACT_LO   12
`define MSR_CTRL_ACT_HI   14

`define MSR_RST_ACTION    3'h3
`define MSR_RST_DROOP     16'h0064
`define MSR_RST_OFFSET    16'h0000
`define MSR_RST_GAIN      16'h0064
`define MSR_RST_SILENCE   16'h000A
`define MSR_RST_PERIOD    16'h0001
`define MSR_RST_WINDOW    16'h0032
`define MSR_RST_RATED     16'h1388

`define MSR_CSRC_SERIAL   2'h2
`define MSR_ST_OFFLINE    0
`define MSR_ST_FRAME      1
`define MSR_ST_UNSYNC     2
`define MSR_NODE_MASTER   8'h01
`define MSR_NODE_SLAVE    8'h02

`define MSR_CLK_NS        40
`define MSR_MS_NS         1000000
`define MSR_MS_PER_SILENT 100
`define MSR_DROOP_DIV     1000000
`define MSR_GAIN_DIV      100

`endif

// [rtl/msr_tick.v]
// Divider that turns the bus clock into a one-cycle millisecond enable.
`timescale 1ns/1ps
module msr_tick #(
  parameter CYCLES = 25000
) (
  input  wire pclk,
  input  wire presetn,
  input  wire run,
  output reg  tick
);
  reg [31:0] cnt_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 32'h0;
      tick  <= 1'b0;
    end else if (!run) begin
      cnt_q <= 32'h0;
      tick  <= 1'b0;
    end else if (cnt_q == CYCLES - 1) begin
      cnt_q <= 32'h0;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 32'h1;
      tick  <= 1'b0;
    end
  end
endmodule // msr_tick

// [verif/master_slave_reference_sharing_tb.sv]
// Self-checking bench for the reference sharing block.
`timescale 1ns/1ps
`include "msr_defs.vh"
module master_slave_reference_sharing_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, run_cmd = 0, flt = 0;
  logic p_on = 0, p_run = 0, p_flt = 0, er;
  logic [7:0] paddr = 0, p_gap = 8'h04;
  logic [31:0] pwdata = 0, rd;
  logic [15:0] fref = 0, ofreq = 0, torq = 0, p_val = 0, ex;
  wire pready, pslverr, rxv, rxr, rxf, tx_valid, tx_run, tx_fault, run_out, peer_fault;
  wire offline_alarm, sync_ok, irq;
  wire [31:0] prdata;
  wire [15:0] rxd, tx_data, freq_ref_out, torque_ref_out;
  wire [7:0] node_addr;
  integer num_errors = 0, n_checks = 0, seed = 28469, wn, i, j, g, o, r, t, dv;
  logic [7:0] ra [10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h24, 8'h30};
  logic [31:0] rv [10] = '{32'h3000, 32'h64, 32'h0, 32'h64, 32'hA, 32'h1, 32'h32, 32'h1388,
                           32'h0, 32'h0};
  logic [31:0] cv [3] = '{32'h3203, 32'h3003, 32'h2203};
  msr_core #(.MS_CYCLES(10)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .freq_ref_in(fref), .out_freq_in(ofreq),
    .out_torque_in(torq), .run_cmd_in(run_cmd), .fault_in(flt), .rx_valid(rxv),
    .rx_data(rxd), .rx_run(rxr), .rx_fault(rxf), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_run(tx_run), .tx_fault(tx_fault), .node_addr(node_addr), .freq_ref_out(freq_ref_out),
    .torque_ref_out(torque_ref_out), .run_out(run_out), .peer_fault(peer_fault),
    .offline_alarm(offline_alarm), .sync_ok(sync_ok), .irq(irq));
  msr_peer u_peer (.pclk(pclk), .presetn(presetn), .on(p_on), .val(p_val), .run(p_run),
    .flt(p_flt), .gap(p_gap), .rx_valid(rxv), .rx_data(rxd), .rx_run(rxr), .rx_fault(rxf));
  initial begin
    forever #20 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    integer n;
    @(posedge pclk); psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk); penable <= 1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    rd = prdata; er = pslverr;
    if (n >= 50) num_errors++;
    psel <= 0; penable <= 0;
  endtask
  task wtx;
    wn = 0;
    do begin @(posedge pclk); wn++; end while (tx_valid !== 1'b1 && wn < 500);
    if (wn >= 500) num_errors++;
  endtask
  function automatic logic [15:0] act(longint f, longint tq, longint rt);
    act = f - 5000 * tq * rt / 1000000;
  endfunction
  function automatic logic in_win(logic [15:0] a, logic [15:0] b);
    integer df, w;
    w = `MSR_RST_WINDOW;
    df = $signed(a) - $signed(b);
    in_win = df <= w && df >= -w;
  endfunction
  task wrap_up;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #(40 * 80000); num_errors++; wrap_up;
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    for (i = 0; i < 10; i++) begin apb(0, ra[i], 0); chk(rd, rv[i]); end
    apb(0, 8'h40, 0); chk(er, 1);
    chk(rd, 0);
    apb(1, 8'h00, 32'h3001);
    for (i = 0; i < 4; i++) begin
      t = i == 0 ? 500 : {$random(seed)} % 1001;
      r = i == 0 ? 100 : i == 1 ? 0 : {$random(seed)} % 1001;
      fref <= 2000 + {$random(seed)} % 4000; ofreq <= {$random(seed)} % 5000; torq <= t;
      run_cmd <= t[0];
      apb(1, 8'h04, r); wtx; wtx;
      apb(0, 8'h28, 0); chk(rd, act(fref, t, r));
      chk(tx_data, r != 0 ? act(fref, t, r) : ofreq);
      chk(tx_run, t[0]);
    end
    apb(1, 8'h00, 32'h3009); wtx; wtx; chk(tx_data, fref);
    apb(1, 8'h14, 3); wtx; wtx; chk(wn, 30);
    chk(node_addr, `MSR_NODE_MASTER);
    p_on <= 1; p_flt <= 1;
    for (j = 0; j < 12 && peer_fault !== 1'b1; j++) @(posedge pclk);
    chk(peer_fault, 1);
    p_flt <= 0;
    for (i = 0; i < 2; i++) begin
      apb(1, 8'h00, 32'h3203 | (i << 2));
      if (i) apb(1, 8'h04, 0);
      for (j = 0; j < 3; j++) begin
        g = j == 0 ? -1000 : $random(seed) % 1001; o = $random(seed) % 10001;
        p_val <= $random(seed) % 3000;
        apb(1, 8'h0C, g & 32'hFFFF); apb(1, 8'h08, o & 32'hFFFF);
        repeat (10) @(posedge pclk);
        ex = 16'(($signed(p_val) * g) / 100 + o);
        chk(i ? torque_ref_out : freq_ref_out, ex);
        dv = $random(seed) % 100; ofreq <= ex + dv[15:0];
        repeat (2) @(posedge pclk);
        chk(sync_ok, i == 0 && in_win(ex, ex + dv[15:0]));
      end
    end
    chk(node_addr, `MSR_NODE_SLAVE);
    p_run <= 1; run_cmd <= 0;
    for (j = 0; j < 3; j++) begin
      apb(1, 8'h00, cv[j]); repeat (8) @(posedge pclk);
      chk(run_out, j == 0 ? p_run : run_cmd);
    end
    flt <= 1; apb(1, 8'h00, 32'h3203); repeat (3) @(posedge pclk); chk(tx_fault, 1);
    apb(1, 8'h00, 32'h1203); repeat (3) @(posedge pclk); chk(tx_fault, 0);
    flt <= 0;
    apb(1, 8'h00, 32'h7203); apb(1, 8'h24, 1); apb(1, 8'h10, 1);
    repeat (1300) @(posedge pclk); chk(offline_alarm, 0);
    p_on <= 0;
    for (j = 0; j < 1300 && offline_alarm !== 1'b1; j++) @(posedge pclk);
    chk(offline_alarm, 1); chk(irq, 1);
    apb(0, 8'h20, 0); chk(rd[0], 1);
    apb(0, 8'h20, 0); chk(rd[0], 0);
    repeat (2) @(posedge pclk); chk(irq, 0);
    presetn <= 0; repeat (2) @(posedge pclk); presetn <= 1;
    apb(1, 8'h00, 32'h7203); apb(1, 8'h10, 0);
    repeat (1500) @(posedge pclk); chk(offline_alarm, 0);
    wrap_up;
  end
endmodule // master_slave_reference_sharing_tb

// [verif/msr_monitor.sv]
// Port-level concurrent checks for the reference sharing block.
`timescale 1ns/1ps
`include "msr_defs.vh"
module msr_monitor #(
  parameter MS_CYCLES = 10
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic [15:0] freq_ref_in,
  input wire logic        fault_in,
  input wire logic        rx_valid,
  input wire logic        rx_fault,
  input wire logic        tx_valid,
  input wire logic        tx_fault,
  input wire logic [7:0]  node_addr,
  input wire logic [15:0] freq_ref_out,
  input wire logic [15:0] torque_ref_out,
  input wire logic        peer_fault
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_wait; psel && penable && !pready |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("access not answered after one wait");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready held too long");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_rzero; !pready |-> prdata == 32'h0000_0000; endproperty
  a_rzero: assert property (p_rzero) else $error("read data outside answer");
  property p_node;
    node_addr == 8'h00 || node_addr == `MSR_NODE_MASTER || node_addr == `MSR_NODE_SLAVE;
  endproperty
  a_node: assert property (p_node) else $error("bad node address");
  property p_txgap; tx_valid |=> !tx_valid [*8]; endproperty
  a_txgap: assert property (p_txgap) else $error("sends too close");
  property p_txf; $rose(tx_fault) |-> $past(fault_in); endproperty
  a_txf: assert property (p_txf) else $error("fault forwarded without cause");
  property p_pf; peer_fault |-> $past(rx_valid) && $past(rx_fault); endproperty
  a_pf: assert property (p_pf) else $error("peer fault without frame");
  property p_fref;
    $changed(freq_ref_out) |-> $past(rx_valid) || freq_ref_out == $past(freq_ref_in);
  endproperty
  a_fref: assert property (p_fref) else $error("frequency reference moved alone");
  property p_tref; $changed(torque_ref_out) |-> $past(rx_valid); endproperty
  a_tref: assert property (p_tref) else $error("torque reference moved alone");
endmodule // msr_monitor
////////////////////////////////////////////////////////////////////////////////
bind msr_core msr_monitor #(.MS_CYCLES(MS_CYCLES)) u_mon (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .freq_ref_in(freq_ref_in), .fault_in(fault_in), .rx_valid(rx_valid), .rx_fault(rx_fault),
  .tx_valid(tx_valid), .tx_fault(tx_fault), .node_addr(node_addr),
  .freq_ref_out(freq_ref_out), .torque_ref_out(torque_ref_out), .peer_fault(peer_fault));

// [verif/msr_peer.sv]
// Peer drive acting as master: sends one frame every gap+1 cycles while on.
`timescale 1ns/1ps
module msr_peer (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        on,
  input  wire logic [15:0] val,
  input  wire logic        run,
  input  wire logic        flt,
  input  wire logic [7:0]  gap,
  output logic             rx_valid,
  output logic [15:0]      rx_data,
  output logic             rx_run,
  output logic             rx_fault
);
  logic [7:0] cnt_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 8'h00; rx_valid <= 1'b0; rx_data <= 16'h0000; rx_run <= 1'b0; rx_fault <= 1'b0;
    end else begin
      cnt_q <= (on && cnt_q < gap) ? cnt_q + 8'h01 : 8'h00;
      rx_valid <= on && cnt_q == gap;
      // Lines are only meaningful with a frame, so they wander between frames.
      if (on && cnt_q == gap) begin
        rx_data <= val; rx_run <= run; rx_fault <= flt;
      end else begin
        rx_data <= ~rx_data; rx_run <= ~rx_run; rx_fault <= ~rx_fault;
      end
    end
  end
endmodule // msr_peer
